//--- rtl/lock_fault_ctrl.sv
`timescale 1ns/1ps
`include "lock_fault_defines.svh"
module lock_fault_ctrl
  import lock_fault_pkg::*;
#(
  parameter int RETRY_WAIT = `RETRY_WAIT_DEFAULT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic setup_we,
  input wire logic [31:0] setup_wdata,
  output logic [31:0] setup_rdata,
  input wire logic fault_clear,
  // analog side
  input wire logic ilimit_lock,
  output logic [2:0] absent_load_current_threshold,
  // responses
  output gate_state_t gate_state,
  output logic fault_out_low,
  output logic lock_reported,
  output logic fault_latched
);
  logic [31:0] setup_q;
  logic [3:0] mode;
  logic [2:0] limit_code;
  logic lock_det;
  logic det_rise;
  logic det_prev_q;
  fault_state_t state_q;
  logic [31:0] wait_q;
  logic [4:0] tries_q;
  logic [4:0] limit_n;
  gate_state_t gate_q;

  // retry limit code to attempt count, zero for unlimited
  function automatic logic [4:0] retry_limit(input logic [2:0] c);
    case (c)
      3'h1: retry_limit = 5'h02;
      3'h2: retry_limit = 5'h03;
      3'h3: retry_limit = 5'h05;
      3'h4: retry_limit = 5'h07;
      3'h5: retry_limit = 5'h0a;
      3'h6: retry_limit = 5'h0f;
      3'h7: retry_limit = 5'h14;
      default: retry_limit = 5'h00;
    endcase
  endfunction

  // gate state chosen by response code
  function automatic gate_state_t gate_for(input logic [3:0] m);
    case (m)
      4'h2, 4'h6: gate_for = GATE_HS_BRAKE;
      4'h3, 4'h7: gate_for = GATE_LS_BRAKE;
      default: gate_for = GATE_HIZ;
    endcase
  endfunction

  // configuration register, reserved bits stay zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      setup_q <= `SETUP_RESET;
    end else if (setup_we) begin
      setup_q <= setup_wdata & `SETUP_WMASK;
    end
  end

  assign setup_rdata = setup_q;
  assign mode = setup_q[`MODE_MSB:`MODE_LSB];
  assign limit_code = setup_q[`RETRY_MSB:`RETRY_LSB];
  assign limit_n = retry_limit(limit_code);
  // threshold goes to the comparator; codes 0 and 1 share a level there
  assign absent_load_current_threshold =
    setup_q[`THR_MSB:`THR_LSB];

  lock_deglitch u_deglitch (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .deg_code(setup_q[`DEG_MSB:`DEG_LSB]),
    .lock_raw(ilimit_lock && mode < 4'h9),
    .lock_det(lock_det)
  );

  // edge of detection starts each fault episode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      det_prev_q <= 1'b0;
    end else begin
      det_prev_q <= lock_det;
    end
  end
  assign det_rise = lock_det && !det_prev_q;

  // fault sequencing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_RUN;
      gate_q <= GATE_DRIVE;
      wait_q <= '0;
      tries_q <= '0;
    end else begin
      case (state_q)
        ST_RUN: begin
          gate_q <= GATE_DRIVE;
          if (det_rise && mode < 4'h4) begin
            state_q <= ST_LATCH;
            gate_q <= gate_for(mode);
          end else if (det_rise && mode < 4'h8) begin
            gate_q <= gate_for(mode);
            wait_q <= '0;
            if (limit_n != 5'h00 && tries_q >= limit_n) begin
              state_q <= ST_LATCH;
            end else begin
              state_q <= ST_WAIT;
            end
          end else if (det_rise && mode == 4'h8) begin
            state_q <= ST_REPORT;
          end
        end
        ST_WAIT: begin
          if (wait_q >= 32'(RETRY_WAIT - 1)) begin
            state_q <= ST_RUN;
            gate_q <= GATE_DRIVE;
            if (tries_q != 5'h1f) begin
              tries_q <= tries_q + 1'b1;
            end
          end else begin
            wait_q <= wait_q + 1'b1;
          end
        end
        ST_LATCH: begin
          if (fault_clear) begin
            state_q <= ST_RUN;
            gate_q <= GATE_DRIVE;
            tries_q <= '0;
          end
        end
        ST_REPORT: begin
          // report flag holds while the detection stands, unless fault_clear ends it
          if (!lock_det || fault_clear) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
          gate_q <= GATE_DRIVE;
        end
      endcase
    end
  end

  assign gate_state = gate_q;
  assign fault_latched = (state_q == ST_LATCH);
  assign lock_reported = (state_q != ST_RUN);
  // pin low for any pending lock fault, including report only
  assign fault_out_low = (state_q == ST_RUN);

  // latched responses, one per gate choice
  a_latch_gate: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode < 4'h2
    |=> state_q == ST_LATCH && gate_state == GATE_HIZ && !fault_out_low)
    else $error("latched tristate response missing");
  a_hs_brake: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode == 4'h2
    |=> fault_latched && gate_state == GATE_HS_BRAKE)
    else $error("high side brake missing");
  a_ls_brake: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode == 4'h3
    |=> fault_latched && gate_state == GATE_LS_BRAKE)
    else $error("low side brake missing");
  // a latched fault stands until software clears it
  a_latch_hold: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    fault_latched && !fault_clear |=> fault_latched && $stable(gate_state))
    else $error("latched fault dropped without clear");

  // auto retry: entry, wait and release
  a_retry_gate: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode inside {[4'h4:4'h7]}
    && (limit_n == 5'h00 || tries_q < limit_n)
    |=> state_q == ST_WAIT && !fault_latched && lock_reported
    && gate_state == (($past(mode) == 4'h6) ? GATE_HS_BRAKE
    : ($past(mode) == 4'h7) ? GATE_LS_BRAKE : GATE_HIZ))
    else $error("auto retry entry wrong");
  a_wait_gate: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_WAIT |-> gate_state != GATE_DRIVE && !fault_out_low)
    else $error("gates driven during retry wait");
  a_retry_end: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_WAIT && wait_q >= 32'(RETRY_WAIT - 1)
    |=> state_q == ST_RUN && gate_state == GATE_DRIVE)
    else $error("auto retry did not clear");
  // each finished wait is one more attempt, saturating
  a_count_step: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_WAIT && wait_q >= 32'(RETRY_WAIT - 1) && tries_q < 5'h1f
    |=> tries_q == $past(tries_q) + 5'h01)
    else $error("retry attempt not counted");
  a_retry_cap: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode inside {[4'h4:4'h7]}
    && limit_n != 5'h00 && tries_q >= limit_n
    |=> fault_latched)
    else $error("retry limit not enforced");

  // report only and disabled codes leave the bridge alone
  a_report_only: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_RUN && det_rise && mode == 4'h8
    |=> lock_reported && gate_state == GATE_DRIVE)
    else $error("report only touched gates");
  a_report_end: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_REPORT && !lock_det |=> state_q == ST_RUN)
    else $error("report did not end with detection");
  a_disabled: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mode >= 4'h9 && state_q == ST_RUN |=> !fault_latched)
    else $error("disabled mode raised a fault");

  // attempt bookkeeping
  a_clear_count: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_LATCH && fault_clear |=> tries_q == 5'h00)
    else $error("retry count not cleared");
  a_limit_map: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    limit_code == 3'h7 |-> limit_n == 5'h14)
    else $error("retry limit decode wrong");
endmodule

//--- inc/lock_fault_defines.svh
// Behaviour
// - threshold field bits 21-19, codes 0,1 equal
// - codes 0,1 latch fault, tristate gates
// - code 2 latches, high-side brake
// - code 3 latches, low-side brake
// - codes 4-7 auto-clear after retry wait
// - retries beyond limit make fault latched
// - code 8 reports only, keeps driving
// - code 9 and above disables detection
// - deglitch field bits 14-12, code 0 immediate
// - retry limit bits 2-0, 0 unlimited
`ifndef LOCK_FAULT_DEFINES_SVH
`define LOCK_FAULT_DEFINES_SVH
`define THR_LSB 19
`define THR_MSB 21
`define MODE_LSB 15
`define MODE_MSB 18
`define DEG_LSB 12
`define DEG_MSB 14
`define RETRY_LSB 0
`define RETRY_MSB 2
`define SETUP_RESET 32'h0000_0000
// writable bits: 30-12 and 10-0; 31 and 11 reserved
`define SETUP_WMASK 32'h7fff_f7ff
`define RETRY_WAIT_DEFAULT 50000
`endif

//--- inc/lock_fault_pkg.sv
package lock_fault_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_LATCH = 4'b0100,
    ST_REPORT = 4'b1000
  } fault_state_t;
  typedef enum logic [1:0] {
    GATE_DRIVE = 2'h0,
    GATE_HIZ = 2'h1,
    GATE_HS_BRAKE = 2'h2,
    GATE_LS_BRAKE = 2'h3
  } gate_state_t;
endpackage

//--- rtl/lock_deglitch.sv
`timescale 1ns/1ps
`include "lock_fault_defines.svh"
module lock_deglitch
  import lock_fault_pkg::*;
#(
  parameter int CW = 16,
  parameter logic [CW*7-1:0] DEG_CYCLES = {16'd5000, 16'd2500, 16'd1000,
    16'd500, 16'd250, 16'd100, 16'd50}
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // filter
  input wire logic [2:0] deg_code,
  input wire logic lock_raw,
  output logic lock_det
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;

  // code n selects entry n-1; code 0 bypasses
  always_comb begin
    limit = DEG_CYCLES[CW-1:0];
    for (int i = 1; i < 8; i++) begin
      if (deg_code == 3'(i)) begin
        limit = DEG_CYCLES[(i-1)*CW +: CW];
      end
    end
  end

  // any drop of the condition restarts the count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (!lock_raw) begin
      cnt_q <= '0;
    end else if (cnt_q < limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign lock_det = (deg_code == 3'h0) ? lock_raw
                  : (lock_raw && cnt_q >= limit);

  // bypass and filtered paths of the detector
  a_deg_bypass: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    deg_code == 3'h0 |-> lock_det == lock_raw)
    else $error("bypass does not follow raw lock");
  a_deg_hold: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    lock_det && deg_code != 3'h0 |-> $past(lock_raw))
    else $error("detection without held condition");
endmodule

//--- dv/motor_stub.sv
`timescale 1ns/1ps
module motor_stub
  import lock_fault_pkg::*;
(
  // command from bench
  input wire logic stall,
  // gate side
  input wire gate_state_t gate_state,
  output logic ilimit_lock
);
  // a stalled rotor trips the limit only while the bridge drives it
  assign ilimit_lock = stall && (gate_state == GATE_DRIVE);
endmodule

//--- dv/test_lock_fault_ctrl.sv
`timescale 1ns/1ps
module test_lock_fault_ctrl
  import lock_fault_pkg::*;
;
  logic clk_sys, reset_n, setup_we, fault_clear, stall, ilimit_lock;
  logic [31:0] setup_wdata, setup_rdata;
  logic [2:0] thr;
  gate_state_t gate_state;
  logic fault_out_low, lock_reported, fault_latched;
  int num_errors, checks, rises;
  logic [3:0] modes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hf};
  gate_state_t eg [7] = '{GATE_HIZ, GATE_HIZ, GATE_HS_BRAKE, GATE_LS_BRAKE,
    GATE_DRIVE, GATE_DRIVE, GATE_DRIVE};
  logic [6:0] erep = 7'h1f;
  logic [6:0] elat = 7'h0f;

  lock_fault_ctrl #(.RETRY_WAIT(10)) lock_fault_ctrl_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .setup_we(setup_we), .setup_wdata(setup_wdata),
    .setup_rdata(setup_rdata), .fault_clear(fault_clear),
    .ilimit_lock(ilimit_lock), .absent_load_current_threshold(thr),
    .gate_state(gate_state), .fault_out_low(fault_out_low),
    .lock_reported(lock_reported), .fault_latched(fault_latched));
  motor_stub motor_stub_i (.stall(stall), .gate_state(gate_state),
    .ilimit_lock(ilimit_lock));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // each retry shows up as a fresh trip of the limit
  always @(posedge ilimit_lock) rises++;

  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(logic [31:0] d);
    @(posedge clk_sys);
    setup_we <= 1'b1;
    setup_wdata <= d;
    @(posedge clk_sys);
    setup_we <= 1'b0;
  endtask
  task clr;
    @(posedge clk_sys);
    fault_clear <= 1'b1;
    @(posedge clk_sys);
    fault_clear <= 1'b0;
  endtask
  task outs(gate_state_t g, logic rep, logic lat);
    chk("gate_state", g, gate_state);
    chk("lock_reported", rep, lock_reported);
    chk("fault_latched", lat, fault_latched);
    chk("fault_out_low", !rep, fault_out_low);
  endtask
  // stall held: auto retry keeps tripping until the limit latches it
  task retry(logic [31:0] d, int er, logic el, gate_state_t g);
    wr(d);
    rises = 0;
    stall <= 1'b1;
    for (int k = 0; k < 200 && fault_latched !== 1'b1; k++) cyc(1);
    chk("retries", 1, er < 0 ? rises >= 10 : rises == er);
    chk("fault_latched", el, fault_latched);
    if (el) chk("gate_state", g, gate_state);
    stall <= 1'b0;
    clr;
    cyc(3);
  endtask

  // watchdog
  initial begin
    cyc(20000);
    num_errors++;
    stop_test;
  end

  initial begin
    reset_n = 1'b0;
    setup_we = 1'b0;
    setup_wdata = 32'h0;
    fault_clear = 1'b0;
    stall = 1'b0;
    cyc(5);
    reset_n <= 1'b1;
    cyc(2);
    chk("setup_rdata", 32'h0, setup_rdata);
    outs(GATE_DRIVE, 1'b0, 1'b0);
    wr(32'hffff_ffff);
    cyc(1);
    chk("setup_rdata", 32'h7fff_f7ff, setup_rdata);
    chk("threshold", 3'h7, thr);
    wr(32'h0008_0000);
    cyc(1);
    chk("threshold", 3'h1, thr);
    // response codes 0-3, 8, 9 and 15, no deglitch
    for (int i = 0; i < 7; i++) begin
      wr({13'h0, modes[i], 15'h0});
      stall <= 1'b1;
      cyc(4);
      outs(eg[i], erep[i], elat[i]);
      stall <= 1'b0;
      cyc(3);
      chk("fault_latched", elat[i], fault_latched);
      clr;
      cyc(3);
      outs(GATE_DRIVE, 1'b0, 1'b0);
    end
    retry(32'h0002_0001, 3, 1'b1, GATE_HIZ);
    retry(32'h0002_0001, 3, 1'b1, GATE_HIZ);
    retry(32'h0003_8002, 4, 1'b1, GATE_LS_BRAKE);
    retry(32'h0002_8001, 3, 1'b1, GATE_HIZ);
    retry(32'h0003_0001, 3, 1'b1, GATE_HS_BRAKE);
    retry(32'h0002_0000, -1, 1'b0, GATE_HIZ);
    // short glitch filtered, long one detected
    wr(32'h0000_1000);
    stall <= 1'b1;
    cyc(20);
    stall <= 1'b0;
    cyc(3);
    outs(GATE_DRIVE, 1'b0, 1'b0);
    stall <= 1'b1;
    cyc(60);
    outs(GATE_HIZ, 1'b1, 1'b1);
    stall <= 1'b0;
    clr;
    cyc(3);
    stop_test;
  end
endmodule
